// ==== dv/ucb_sink.sv ====
`timescale 1ns/1ps
module ucb_sink (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control from bench
   input wire logic stall_i,
   // transaction side
   input wire logic valid_i,
   input wire logic rd_i,
   input wire logic [31:0] addr_i,
   input wire logic [5:0] bytes_i,
   input wire logic [255:0] data_i,
   output logic ready_o,
   output logic confirm_o
);
   ucb_pkg::bus_t log_q[$];
   logic [1:0] wait_q;
   // stall holds the head in place
   assign ready_o = !stall_i;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 2'h0;
         confirm_o <= 1'h0;
      end else begin
         confirm_o <= (wait_q == 2'h1);
         if (valid_i && ready_o) begin
            log_q.push_back('{rd_i, addr_i, bytes_i, data_i});
            wait_q <= 2'h3;
         end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule

// ==== dv/uncached_combining_buffer_assertions.sv ====
`timescale 1ns/1ps
module ucb_chk #(
   parameter int NUM_ENTRIES = 4,
   parameter int FLUSH_THRESH = 1,
   parameter int CW = 3
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic REQ_VALID_I,
   input wire logic REQ_DONE_O,
   input wire logic REQ_ACCEPT_O,
   input wire logic BUS_VALID_O,
   input wire logic BUS_READY_I,
   input wire logic BUS_READ_O,
   input wire logic [31:0] BUS_ADDR_O,
   input wire logic [5:0] BUS_BYTES_O,
   input wire logic BUS_CONFIRM_I,
   input wire logic PENDING_O,
   input wire logic [CW-1:0] ENTRIES_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_take;
      REQ_VALID_I && !REQ_DONE_O;
   endsequence
   sequence s_answer;
      REQ_DONE_O ##1 !REQ_DONE_O;
   endsequence
   property p_answer;
      s_take |=> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("request answer late or long");
   property p_refuse;
      REQ_DONE_O && !REQ_ACCEPT_O |-> ENTRIES_O == NUM_ENTRIES;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused with free entry");
   property p_cap;
      ENTRIES_O <= NUM_ENTRIES;
   endproperty
   a_cap: assert property (p_cap) else $error("entry count above size");
   property p_issue;
      $rose(BUS_VALID_O) |-> $rose(PENDING_O);
   endproperty
   a_issue: assert property (p_issue) else $error("issue without pending flag");
   property p_hold;
      PENDING_O && !BUS_CONFIRM_I |=> PENDING_O;
   endproperty
   a_hold: assert property (p_hold) else $error("pending dropped unconfirmed");
   property p_clear;
      PENDING_O && BUS_CONFIRM_I |=> !PENDING_O;
   endproperty
   a_clear: assert property (p_clear) else $error("pending kept after confirm");
   property p_stable;
      BUS_VALID_O && !BUS_READY_I |=> BUS_VALID_O && $stable(BUS_ADDR_O) && $stable(BUS_BYTES_O) &&
         $stable(BUS_READ_O);
   endproperty
   a_stable: assert property (p_stable) else $error("head changed while stalled");
   property p_align;
      BUS_VALID_O |-> $onehot(BUS_BYTES_O) && BUS_BYTES_O <= 6'h20 && (BUS_ADDR_O & (BUS_BYTES_O - 6'h1)) == 0;
   endproperty
   a_align: assert property (p_align) else $error("transaction not aligned");
   property p_drain;
      ENTRIES_O >= FLUSH_THRESH && !PENDING_O && !BUS_VALID_O |=> PENDING_O;
   endproperty
   a_drain: assert property (p_drain) else $error("drain did not start");
endmodule
bind uncached_combining_buffer ucb_chk #(.NUM_ENTRIES(NUM_ENTRIES), .FLUSH_THRESH(FLUSH_THRESH), .CW(CW)) u_chk (
   .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .REQ_VALID_I(REQ_VALID_I), .REQ_DONE_O(REQ_DONE_O),
   .REQ_ACCEPT_O(REQ_ACCEPT_O), .BUS_VALID_O(BUS_VALID_O), .BUS_READY_I(BUS_READY_I), .BUS_READ_O(BUS_READ_O),
   .BUS_ADDR_O(BUS_ADDR_O), .BUS_BYTES_O(BUS_BYTES_O), .BUS_CONFIRM_I(BUS_CONFIRM_I), .PENDING_O(PENDING_O),
   .ENTRIES_O(ENTRIES_O));

// ==== dv/uncached_combining_buffer_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module uncached_combining_buffer_tb;
   typedef struct packed {
      logic [1:0] cmd;
      logic [31:0] addr;
      logic [3:0] size;
      logic [5:0] bytes;
   } row_t;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic valid = 1'h0;
   logic stall = 1'h0;
   logic [1:0] cmd = 2'h0;
   logic [31:0] addr = 32'h0;
   logic [3:0] size = 4'h0;
   logic [63:0] wdata = 64'h0;
   logic done, acc, bvalid, bready, bread, confirm, pend;
   logic [31:0] baddr;
   logic [5:0] bbytes;
   logic [255:0] bdata;
   logic [2:0] ents;
   logic nc_valid, nc_ready, nc_read, nc_confirm;
   logic [31:0] nc_addr;
   logic [5:0] nc_bytes;
   logic [255:0] nc_data;
   logic [2:0] nc_ents;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   ucb_pkg::bus_t tx;
   row_t rows [5] = '{
      '{ucb_pkg::CMD_WRITE, 32'hFFF00108, 4'h4, 6'h04},
      '{ucb_pkg::CMD_WRITE, 32'hFFF00110, 4'h8, 6'h08},
      '{ucb_pkg::CMD_WRITE, 32'hFFF00123, 4'h1, 6'h01},
      '{ucb_pkg::CMD_WRITE, 32'hFFF00132, 4'h2, 6'h02},
      '{ucb_pkg::CMD_READ, 32'hFFF00204, 4'h4, 6'h04}};
   uncached_combining_buffer #(.FLUSH_THRESH(2)) u_dut (
      .REF_CLK_I(clk), .RST_I(rst), .REQ_VALID_I(valid), .REQ_CMD_I(cmd), .REQ_ADDR_I(addr),
      .REQ_SIZE_I(size), .REQ_DATA_I(wdata), .REQ_DONE_O(done), .REQ_ACCEPT_O(acc), .BUS_VALID_O(bvalid),
      .BUS_READY_I(bready), .BUS_READ_O(bread), .BUS_ADDR_O(baddr), .BUS_BYTES_O(bbytes), .BUS_DATA_O(bdata),
      .BUS_CONFIRM_I(confirm), .PENDING_O(pend), .ENTRIES_O(ents));
   ucb_sink u_sink (
      .clk_i(clk), .rst_i(rst), .stall_i(stall), .valid_i(bvalid), .rd_i(bread), .addr_i(baddr),
      .bytes_i(bbytes), .data_i(bdata), .ready_o(bready), .confirm_o(confirm));
   // second buffer without combining sees the same requests
   uncached_combining_buffer #(.FLUSH_THRESH(2), .COMBINE(1'b0)) u_nc (
      .REF_CLK_I(clk), .RST_I(rst), .REQ_VALID_I(valid), .REQ_CMD_I(cmd), .REQ_ADDR_I(addr),
      .REQ_SIZE_I(size), .REQ_DATA_I(wdata), .REQ_DONE_O(), .REQ_ACCEPT_O(), .BUS_VALID_O(nc_valid),
      .BUS_READY_I(nc_ready), .BUS_READ_O(nc_read), .BUS_ADDR_O(nc_addr), .BUS_BYTES_O(nc_bytes),
      .BUS_DATA_O(nc_data), .BUS_CONFIRM_I(nc_confirm), .PENDING_O(), .ENTRIES_O(nc_ents));
   ucb_sink u_nc_sink (
      .clk_i(clk), .rst_i(rst), .stall_i(1'h0), .valid_i(nc_valid), .rd_i(nc_read), .addr_i(nc_addr),
      .bytes_i(nc_bytes), .data_i(nc_data), .ready_o(nc_ready), .confirm_o(nc_confirm));
   always #5 clk = ~clk;
   task automatic close_out();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // offer one request and hold it until answered
   task automatic req(input logic [1:0] c, input logic [31:0] a, input logic [3:0] s, input logic ok);
      int n = 0;
      @(negedge clk);
      cmd = c;
      addr = a;
      size = s;
      wdata = {~a, a};
      valid = 1'h1;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (done !== 1'h1 && n < 20);
      `CHK({done, acc}, {1'h1, ok})
      @(negedge clk);
      valid = 1'h0;
   endtask
   // take the next transaction seen by the sink
   task automatic pop(input logic rd, input logic [31:0] a, input logic [5:0] b);
      int n = 0;
      while (u_sink.log_q.size() == 0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      tx = (u_sink.log_q.size() != 0) ? u_sink.log_q.pop_front() : '0;
      `CHK({tx.rd, tx.addr, tx.bytes}, {rd, a, b})
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      `CHK({bvalid, pend, ents, done}, 6'h0)
      req(ucb_pkg::CMD_BARRIER, 32'h0, 4'h4, 1'h1);
      repeat (4) @(negedge clk);
      `CHK({ents, pend, bvalid}, 5'h0)
      foreach (rows[i]) begin
         req(rows[i].cmd, rows[i].addr, rows[i].size, 1'h1);
         if (rows[i].cmd == ucb_pkg::CMD_WRITE) req(ucb_pkg::CMD_BARRIER, 32'h0, 4'h4, 1'h1);
         pop(rows[i].cmd == ucb_pkg::CMD_READ, rows[i].addr, rows[i].bytes);
         if (rows[i].size >= 4'h4 && rows[i].cmd == ucb_pkg::CMD_WRITE) `CHK(tx.data[31:0], rows[i].addr)
      end
      // threshold of two holds a lone entry
      req(ucb_pkg::CMD_WRITE, 32'hFFF00400, 4'h4, 1'h1);
      repeat (5) @(negedge clk);
      `CHK({pend, ents}, 4'h1)
      req(ucb_pkg::CMD_WRITE, 32'hFFF00440, 4'h4, 1'h1);
      pop(1'h0, 32'hFFF00400, 6'h04);
      req(ucb_pkg::CMD_BARRIER, 32'h0, 4'h4, 1'h1);
      pop(1'h0, 32'hFFF00440, 6'h04);
      // merge, overwrite and entry width
      req(ucb_pkg::CMD_WRITE, 32'hFFF0010C, 4'h4, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF00108, 4'h8, 1'h1);
      `CHK(ents, 3'h1)
      `CHK(nc_ents, 3'h2)
      req(ucb_pkg::CMD_WRITE, 32'hFFF00100, 4'h4, 1'h1);
      pop(1'h0, 32'hFFF00108, 6'h08);
      `CHK(tx.data[63:0], {~32'hFFF00108, 32'hFFF00108})
      req(ucb_pkg::CMD_BARRIER, 32'h0, 4'h4, 1'h1);
      pop(1'h0, 32'hFFF00100, 6'h04);
      // narrow write, fence and full buffer with a stalled sink
      stall = 1'h1;
      req(ucb_pkg::CMD_WRITE, 32'hFFF00300, 4'h4, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF00304, 4'h4, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF00306, 4'h2, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF00340, 4'h4, 1'h1);
      req(ucb_pkg::CMD_BARRIER, 32'h0, 4'h4, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF00344, 4'h4, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF00380, 4'h4, 1'h1);
      req(ucb_pkg::CMD_WRITE, 32'hFFF003C0, 4'h4, 1'h0);
      `CHK({ents, pend}, 4'h9)
      stall = 1'h0;
      pop(1'h0, 32'hFFF00300, 6'h08);
      pop(1'h0, 32'hFFF00306, 6'h02);
      pop(1'h0, 32'hFFF00340, 6'h04);
      pop(1'h0, 32'hFFF00344, 6'h04);
      req(ucb_pkg::CMD_BARRIER, 32'h0, 4'h4, 1'h1);
      pop(1'h0, 32'hFFF00380, 6'h04);
      repeat (10) @(negedge clk);
      `CHK({ents, pend, u_sink.log_q.size() == 0}, 5'h1)
      // reset in mid-run drops a held entry, then a request is taken at once
      req(ucb_pkg::CMD_WRITE, 32'hFFF00500, 4'h4, 1'h1);
      `CHK(ents, 3'h1)
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      `CHK({ents, pend, bvalid, done, acc}, 7'h0)
      req(ucb_pkg::CMD_WRITE, 32'hFFF00520, 4'h4, 1'h1);
      `CHK({ents, pend}, 4'h2)
      close_out();
   end
endmodule

// ==== rtl/ucb_pkg.sv ====
package ucb_pkg;

   // line and slot geometry
   localparam int LINE_BYTES = 32;
   localparam int WORD_BYTES = 4;
   localparam int NSLOT = 8;
   localparam int ADDR_W = 32;
   localparam int LINE_LSB = 5;
   localparam int LINE_W = ADDR_W - LINE_LSB;
   localparam int BUS_DATA_W = NSLOT * 32;

   // default configuration
   localparam int DEF_ENTRIES = 4;
   localparam int DEF_ENTRY_BYTES = 8;
   localparam int DEF_FLUSH = 1;
   localparam bit DEF_COMBINE = 1'b1;
   localparam int DEF_FIFO_DEPTH = 8;
   localparam int DEMAND_W = 6;

   // request commands
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_BARRIER = 2'h2;

   // values after reset
   localparam logic RST_FLAG = 1'b0;

   typedef enum logic [1:0] {
      DR_IDLE = 2'b00,
      DR_WAIT = 2'b01
   } drain_t;

   typedef struct packed {
      logic vld;
      logic [3:0] bytes;
      logic [1:0] boff;
      logic [31:0] data;
   } slot_t;

   typedef struct packed {
      logic vld;
      logic [LINE_W-1:0] line;
      logic fence;
      logic busy;
      logic rd;
      logic [5:0] used;
      slot_t [NSLOT-1:0] slot;
   } ent_t;

   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [5:0] bytes;
      logic [BUS_DATA_W-1:0] data;
   } bus_t;

endpackage

// ==== rtl/uncached_combining_buffer.sv ====
`timescale 1ns/1ps
// Summary of operation
// - entry count and entry width in bytes are configurable, defaults four and eight
// - combining mode merges requests; non-combining gives each request its own entry
// - draining starts once occupied entries reach the flush threshold, default one
// - draining also starts while a read or barrier is held
// - entry holds line of word slots, line address, fence, busy and type
// - pending flag set on handing a transaction; no further hand-over until cleared
// - barrier fences youngest entry and bumps flush demand; dropped when empty
// - combining search runs youngest to oldest for same line, type, not busy
// - search stops at a fenced entry or one of different type
// - only 4 or 8 byte requests merge; narrower ones allocate fresh
// - newer request to same slot replaces the older one
// - without merge, a free entry becomes youngest with type and line address
// - each offered request answered accept or refuse; requester retires accepted ones
// - request lands in the slot chosen by its offset within the line
// - a request merges only if the entry's used bytes stay within the entry width
// - accepting a read increments flush demand
// - first valid slot of oldest entry, scanning up from slot 0, goes out
// - consecutive valid full-word slots coalesce, rounded to an aligned power of two
// - flush demand drops on sending a read or finishing a fenced entry
// - oldest entry needing several transactions is marked busy

module ucb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = ucb_pkg::DEF_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   typedef struct packed {
      logic [DEPTH-1:0] vld;
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } fst_t;

   fst_t q;
   fst_t d;

   always_comb begin
      logic placed;
      placed = 1'b0;
      d = q;
      // head leaves, the rest shift toward the head
      if (q.vld[0] && out_ready_i) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            d.vld[i] = q.vld[i+1];
            d.mem[i] = q.mem[i+1];
         end
         d.vld[DEPTH-1] = 1'b0;
      end
      if (in_valid_i && !q.vld[DEPTH-1]) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (!placed && !d.vld[i]) begin
               d.vld[i] = 1'b1;
               d.mem[i] = in_data_i;
               placed = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_ready_o = !q.vld[DEPTH-1];
   assign out_valid_o = q.vld[0];
   assign out_data_o = q.mem[0];

endmodule

module uncached_combining_buffer #(
   parameter int NUM_ENTRIES = ucb_pkg::DEF_ENTRIES,
   parameter int ENTRY_BYTES = ucb_pkg::DEF_ENTRY_BYTES,
   parameter int FLUSH_THRESH = ucb_pkg::DEF_FLUSH,
   parameter bit COMBINE = ucb_pkg::DEF_COMBINE,
   parameter int FIFO_DEPTH = ucb_pkg::DEF_FIFO_DEPTH,
   localparam int CW = $clog2(NUM_ENTRIES + 1)
) (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // request from cache queue
   input wire logic REQ_VALID_I,
   input wire logic [1:0] REQ_CMD_I,
   input wire logic [31:0] REQ_ADDR_I,
   input wire logic [3:0] REQ_SIZE_I,
   input wire logic [63:0] REQ_DATA_I,
   // answer to request
   output logic REQ_DONE_O,
   output logic REQ_ACCEPT_O,
   // toward system interface
   output logic BUS_VALID_O,
   input wire logic BUS_READY_I,
   output logic BUS_READ_O,
   output logic [31:0] BUS_ADDR_O,
   output logic [5:0] BUS_BYTES_O,
   output logic [255:0] BUS_DATA_O,
   input wire logic BUS_CONFIRM_I,
   // status
   output logic PENDING_O,
   output logic [CW-1:0] ENTRIES_O
);

   typedef struct packed {
      ucb_pkg::ent_t [NUM_ENTRIES-1:0] ent;
      logic [CW-1:0] cnt;
      logic [ucb_pkg::DEMAND_W-1:0] demand;
      ucb_pkg::drain_t st;
      logic pend;
      logic done;
      logic acc;
   } st_t;

   st_t q;
   st_t d;
   logic push;
   logic fifo_ready;
   ucb_pkg::bus_t push_word;
   ucb_pkg::bus_t head_word;

   // bytes newly occupied when a request lands at slot s
   function automatic logic [5:0] new_bytes(input ucb_pkg::ent_t e, input logic [2:0] s,
                                            input logic [3:0] sz);
      logic [2:0] lo;
      logic [5:0] nb;
      lo = {s[2:1], 1'b0};
      nb = '0;
      if (sz == 4'h8) begin
         if (!e.slot[lo].vld) nb = nb + 6'h4;
         if (!e.slot[lo+3'h1].vld) nb = nb + 6'h4;
      end else if (!e.slot[s].vld) begin
         nb = {2'h0, sz};
      end
      return nb;
   endfunction

   // largest aligned word count for a start slot
   function automatic int align_words(input logic [2:0] f);
      if (f == 3'h0) return ucb_pkg::NSLOT;
      if (f[0]) return 1;
      if (f[1]) return 2;
      return 4;
   endfunction

   function automatic int pow2_floor(input int n);
      if (n >= 8) return 8;
      if (n >= 4) return 4;
      if (n >= 2) return 2;
      return 1;
   endfunction

   always_comb begin
      ucb_pkg::ent_t e;
      logic [2:0] f;
      logic [2:0] s;
      logic [2:0] lo;
      logic found;
      logic stop;
      logic hit;
      logic empty;
      logic rd;
      int n;
      int m;
      int idx;
      logic [ucb_pkg::DEMAND_W-1:0] dec;
      e = q.ent[0];
      f = '0;
      s = REQ_ADDR_I[4:2];
      lo = {s[2:1], 1'b0};
      found = 1'b0;
      stop = 1'b0;
      hit = 1'b0;
      empty = 1'b1;
      rd = (REQ_CMD_I == ucb_pkg::CMD_READ);
      n = 1;
      m = 1;
      idx = 0;
      dec = '0;
      push = 1'b0;
      push_word = '0;
      d = q;
      d.done = ucb_pkg::RST_FLAG;
      d.acc = ucb_pkg::RST_FLAG;

      if (q.pend && BUS_CONFIRM_I) begin
         d.pend = 1'b0;
         d.st = ucb_pkg::DR_IDLE;
      end

      // drain the oldest entry
      if (q.st == ucb_pkg::DR_IDLE && q.cnt != '0 && fifo_ready &&
          (int'(q.cnt) >= FLUSH_THRESH || q.demand != '0)) begin
         for (int i = 0; i < ucb_pkg::NSLOT; i++) begin
            if (!found && e.slot[i].vld) begin
               f = 3'(i);
               found = 1'b1;
            end
         end
         if (e.slot[f].bytes == 4'h4) begin
            for (int i = 1; i < ucb_pkg::NSLOT; i++) begin
               if (!stop && int'(f) + i < ucb_pkg::NSLOT && e.slot[int'(f)+i].vld &&
                   e.slot[int'(f)+i].bytes == 4'h4) begin
                  n = n + 1;
               end else begin
                  stop = 1'b1;
               end
            end
         end
         m = pow2_floor((n < align_words(f)) ? n : align_words(f));
         push_word.rd = e.rd;
         push_word.addr = {e.line, f, e.slot[f].boff};
         push_word.bytes = (m == 1) ? {2'h0, e.slot[f].bytes} : 6'(m * ucb_pkg::WORD_BYTES);
         for (int i = 0; i < ucb_pkg::NSLOT; i++) begin
            if (i < m) begin
               push_word.data[i*32 +: 32] = e.slot[int'(f)+i].data;
               e.slot[int'(f)+i].vld = 1'b0;
            end
         end
         push = 1'b1;
         d.pend = 1'b1;
         d.st = ucb_pkg::DR_WAIT;
         for (int i = 0; i < ucb_pkg::NSLOT; i++) begin
            if (e.slot[i].vld) empty = 1'b0;
         end
         if (e.rd) dec = dec + 1'b1;
         if (empty) begin
            if (e.fence) dec = dec + 1'b1;
            for (int i = 0; i < NUM_ENTRIES - 1; i++) begin
               d.ent[i] = q.ent[i+1];
            end
            d.ent[NUM_ENTRIES-1] = '0;
            d.cnt = q.cnt - 1'b1;
         end else begin
            e.busy = 1'b1;
            d.ent[0] = e;
         end
         d.demand = q.demand - dec;
      end

      // take one offered request, answer next cycle
      if (REQ_VALID_I && !q.done) begin
         d.done = 1'b1;
         stop = 1'b0;
         if (REQ_CMD_I == ucb_pkg::CMD_BARRIER) begin
            d.acc = 1'b1;
            if (d.cnt != '0) begin
               d.ent[int'(d.cnt)-1].fence = 1'b1;
               d.demand = d.demand + 1'b1;
            end
         end else begin
            if (COMBINE && (REQ_SIZE_I == 4'h4 || REQ_SIZE_I == 4'h8)) begin
               for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
                  if (!stop && !hit && i < int'(d.cnt)) begin
                     if (d.ent[i].fence || d.ent[i].rd != rd) begin
                        stop = 1'b1;
                     end else if (d.ent[i].line == REQ_ADDR_I[31:5] && !d.ent[i].busy &&
                                  int'(d.ent[i].used) + int'(new_bytes(d.ent[i], s, REQ_SIZE_I))
                                  <= ENTRY_BYTES) begin
                        hit = 1'b1;
                        idx = i;
                     end
                  end
               end
            end
            if (!hit && int'(d.cnt) < NUM_ENTRIES) begin
               idx = int'(d.cnt);
               d.ent[idx] = '0;
               d.ent[idx].vld = 1'b1;
               d.ent[idx].rd = rd;
               d.ent[idx].line = REQ_ADDR_I[31:5];
               d.cnt = d.cnt + 1'b1;
               hit = 1'b1;
            end
            if (hit) begin
               d.acc = 1'b1;
               d.ent[idx].used = d.ent[idx].used + new_bytes(d.ent[idx], s, REQ_SIZE_I);
               if (REQ_SIZE_I == 4'h8) begin
                  d.ent[idx].slot[lo] = {1'b1, 4'h4, 2'h0, REQ_DATA_I[31:0]};
                  d.ent[idx].slot[lo+3'h1] = {1'b1, 4'h4, 2'h0, REQ_DATA_I[63:32]};
               end else begin
                  d.ent[idx].slot[s] = {1'b1, REQ_SIZE_I, REQ_ADDR_I[1:0], REQ_DATA_I[31:0]};
               end
               if (rd) d.demand = d.demand + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ucb_fifo #(
      .WIDTH($bits(ucb_pkg::bus_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_out_fifo (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(push_word),
      .out_valid_o(BUS_VALID_O),
      .out_ready_i(BUS_READY_I),
      .out_data_o(head_word)
   );

   assign BUS_READ_O = head_word.rd;
   assign BUS_ADDR_O = head_word.addr;
   assign BUS_BYTES_O = head_word.bytes;
   assign BUS_DATA_O = head_word.data;
   assign REQ_DONE_O = q.done;
   assign REQ_ACCEPT_O = q.acc;
   assign PENDING_O = q.pend;
   assign ENTRIES_O = q.cnt;

endmodule
